// ### logic/cpot_pkg.sv
package cpot_pkg;

  localparam int ADR_W = 8;
  localparam int IDX_W = 6;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL_MAIN = 6'h00;
  localparam logic [5:0] IDX_CTRL_WAVE = 6'h01;
  localparam logic [5:0] IDX_EVT_CTRL = 6'h04;
  localparam logic [5:0] IDX_INT_EN = 6'h05;
  localparam logic [5:0] IDX_IRQ_FLAG = 6'h06;
  localparam logic [5:0] IDX_STATUS = 6'h07;
  localparam logic [5:0] IDX_TEMP = 6'h09;
  localparam logic [5:0] IDX_COUNT_LO = 6'h0a;
  localparam logic [5:0] IDX_COUNT_HI = 6'h0b;
  localparam logic [5:0] IDX_SNAP_LO = 6'h0c;
  localparam logic [5:0] IDX_SNAP_HI = 6'h0d;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  // field positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_TICK_LO = 1;
  localparam int BIT_RESTART = 4;
  localparam int BIT_MODE_LO = 0;
  localparam int BIT_WAVE_ON = 4;
  localparam int BIT_WAVE_INIT = 5;
  localparam int BIT_ASYNC = 6;
  localparam int BIT_EVT_ON = 0;
  localparam int BIT_EDGE = 4;
  localparam int BIT_FILTER = 6;
  localparam int BIT_FLAG = 0;
  // modes
  localparam logic [2:0] MODE_PERIODIC = 3'h0;
  localparam logic [2:0] MODE_TIMEOUT = 3'h1;
  localparam logic [2:0] MODE_CAPTURE = 3'h2;
  localparam logic [2:0] MODE_FREQ = 3'h3;
  localparam logic [2:0] MODE_PW = 3'h4;
  localparam logic [2:0] MODE_FREQ_PW = 3'h5;
  localparam logic [2:0] MODE_SINGLE = 3'h6;
  localparam logic [2:0] MODE_PWM8 = 3'h7;
  // tick sources
  localparam logic [1:0] TICK_DIV1 = 2'h0;
  localparam logic [1:0] TICK_DIV2 = 2'h1;
  localparam logic [1:0] TICK_PARTNER = 2'h2;
  localparam int FILTER_LEN = 4;

  typedef struct packed {
    logic enable;
    logic [1:0] tickSel;
    logic restartFollow;
    logic [2:0] opMode;
    logic waveOn;
    logic waveInit;
    logic asyncOut;
    logic evInOn;
    logic edgeSel;
    logic filterOn;
  } cpot_cfg_type;

  typedef enum logic [1:0] {
    SS_IDLE = 2'b00,
    SS_ARM = 2'b01,
    SS_RUN = 2'b10,
    SS_HOLD = 2'b11
  } cpot_ss_type;

endpackage : cpot_pkg

// ### logic/cpot_timer.sv
// The placing of the registers and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
module cpot_timer #(
  parameter int FILT_LEN = cpot_pkg::FILTER_LEN
) (
  // clock, reset, freeze
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // wishbone classic slave
  input wire logic [cpot_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // event routing network
  input wire logic eventIn,
  output logic eventOut,
  // companion timer
  input wire logic partnerTick,
  input wire logic partnerRestart,
  // waveform pin
  output logic waveOut,
  output logic waveOeN
);

  cpot_pkg::cpot_cfg_type cfg;
  cpot_pkg::cpot_ss_type ss_reg;
  cpot_pkg::cpot_ss_type ss_next;
  logic [7:0] ctrlMain_reg;
  logic [7:0] ctrlWave_reg;
  logic [7:0] evtCtrl_reg;
  logic [7:0] intEn_reg;
  logic [7:0] temp_reg;
  logic [15:0] count_reg;
  logic [15:0] snap_reg;
  logic flag_reg;
  logic ack_reg;
  logic [31:0] rdData_reg;
  logic div2_reg;
  logic [FILT_LEN-1:0] filtShift_reg;
  logic filt_reg;
  logic evPrev_reg;
  logic enPrev_reg;
  logic evOut_reg;
  logic [1:0] fpPhase_reg;
  logic [1:0] fpPhase_next;
  logic access;
  logic wrStrobe;
  logic rdStrobe;
  logic [cpot_pkg::IDX_W-1:0] idx;
  logic tick;
  logic evLvl;
  logic rise;
  logic fall;
  logic actRise;
  logic actFall;
  logic actSel;
  logic ssTrig;
  logic hit;
  logic capture;
  logic clear;
  logic incr;
  logic snapLoRead;
  logic pwmLvl;
  logic running;

  assign cfg.enable = ctrlMain_reg[cpot_pkg::BIT_ENABLE];
  assign cfg.tickSel = ctrlMain_reg[cpot_pkg::BIT_TICK_LO +: 2];
  assign cfg.restartFollow = ctrlMain_reg[cpot_pkg::BIT_RESTART];
  assign cfg.opMode = ctrlWave_reg[cpot_pkg::BIT_MODE_LO +: 3];
  assign cfg.waveOn = ctrlWave_reg[cpot_pkg::BIT_WAVE_ON];
  assign cfg.waveInit = ctrlWave_reg[cpot_pkg::BIT_WAVE_INIT];
  assign cfg.asyncOut = ctrlWave_reg[cpot_pkg::BIT_ASYNC];
  assign cfg.evInOn = evtCtrl_reg[cpot_pkg::BIT_EVT_ON];
  assign cfg.edgeSel = evtCtrl_reg[cpot_pkg::BIT_EDGE];
  assign cfg.filterOn = evtCtrl_reg[cpot_pkg::BIT_FILTER];

  // bus: request taken on the edge where it is first seen, ack in the next cycle
  assign access = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wrStrobe = access & wb_we_i & wb_sel_i[0];
  assign rdStrobe = access & ~wb_we_i;
  assign idx = wb_adr_i[cpot_pkg::ADR_W-1:2];
  assign snapLoRead = rdStrobe & (idx == cpot_pkg::IDX_SNAP_LO);
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdData_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_reg <= 1'b0;
    end else if (clkEn) begin
      ack_reg <= access;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdData_reg <= 32'h00000000;
    end else if (clkEn && rdStrobe) begin
      case (idx)
        cpot_pkg::IDX_CTRL_MAIN: rdData_reg <= {24'h000000, ctrlMain_reg};
        cpot_pkg::IDX_CTRL_WAVE: rdData_reg <= {24'h000000, ctrlWave_reg};
        cpot_pkg::IDX_EVT_CTRL: rdData_reg <= {24'h000000, evtCtrl_reg};
        cpot_pkg::IDX_INT_EN: rdData_reg <= {24'h000000, intEn_reg};
        cpot_pkg::IDX_IRQ_FLAG: rdData_reg <= {31'h00000000, flag_reg};
        cpot_pkg::IDX_STATUS: rdData_reg <= {31'h00000000, running};
        cpot_pkg::IDX_TEMP: rdData_reg <= {24'h000000, temp_reg};
        cpot_pkg::IDX_COUNT_LO: rdData_reg <= {24'h000000, count_reg[7:0]};
        cpot_pkg::IDX_COUNT_HI: rdData_reg <= {24'h000000, temp_reg};
        cpot_pkg::IDX_SNAP_LO: rdData_reg <= {24'h000000, snap_reg[7:0]};
        cpot_pkg::IDX_SNAP_HI: rdData_reg <= {24'h000000, temp_reg};
        default: rdData_reg <= 32'h00000000;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrlMain_reg <= cpot_pkg::RST_BYTE;
      ctrlWave_reg <= cpot_pkg::RST_BYTE;
      evtCtrl_reg <= cpot_pkg::RST_BYTE;
      intEn_reg <= cpot_pkg::RST_BYTE;
    end else if (clkEn && wrStrobe) begin
      case (idx)
        cpot_pkg::IDX_CTRL_MAIN: ctrlMain_reg <= wb_dat_i[7:0] & 8'h17;
        cpot_pkg::IDX_CTRL_WAVE: ctrlWave_reg <= wb_dat_i[7:0] & 8'h77;
        cpot_pkg::IDX_EVT_CTRL: evtCtrl_reg <= wb_dat_i[7:0] & 8'h51;
        cpot_pkg::IDX_INT_EN: intEn_reg <= wb_dat_i[7:0] & 8'h01;
        default: ;
      endcase
    end
  end

  // shared byte latch for coherent 16-bit access: low byte on writes, high byte on reads
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      temp_reg <= cpot_pkg::RST_BYTE;
    end else if (clkEn) begin
      if (wrStrobe && (idx == cpot_pkg::IDX_TEMP || idx == cpot_pkg::IDX_COUNT_LO
          || idx == cpot_pkg::IDX_SNAP_LO)) begin
        temp_reg <= wb_dat_i[7:0];
      end else if (rdStrobe && idx == cpot_pkg::IDX_COUNT_LO) begin
        temp_reg <= count_reg[15:8];
      end else if (snapLoRead) begin
        temp_reg <= snap_reg[15:8];
      end
    end
  end

  // tick source
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div2_reg <= 1'b0;
    end else if (clkEn) begin
      div2_reg <= ~div2_reg;
    end
  end

  always_comb begin
    case (cfg.tickSel)
      cpot_pkg::TICK_DIV1: tick = 1'b1;
      cpot_pkg::TICK_DIV2: tick = div2_reg;
      cpot_pkg::TICK_PARTNER: tick = partnerTick;
      default: tick = 1'b0;
    endcase
  end

  // noise filter: output follows only after a run of equal samples
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      filtShift_reg <= '0;
      filt_reg <= 1'b0;
    end else if (clkEn) begin
      filtShift_reg <= {filtShift_reg[FILT_LEN-2:0], eventIn};
      if (&filtShift_reg) begin
        filt_reg <= 1'b1;
      end else if (~|filtShift_reg) begin
        filt_reg <= 1'b0;
      end
    end
  end

  assign evLvl = cfg.filterOn ? filt_reg : eventIn;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      evPrev_reg <= 1'b0;
      enPrev_reg <= 1'b0;
    end else if (clkEn) begin
      evPrev_reg <= evLvl;
      enPrev_reg <= cfg.enable;
    end
  end

  // edge detection, gated by event input enable
  assign rise = cfg.evInOn & evLvl & ~evPrev_reg;
  assign fall = cfg.evInOn & ~evLvl & evPrev_reg;
  assign actRise = cfg.edgeSel ? fall : rise;
  assign actFall = cfg.edgeSel ? rise : fall;
  assign actSel = cfg.edgeSel ? fall : rise;
  assign ssTrig = cfg.edgeSel ? (rise | fall) : rise;

  // per-mode decisions on this cycle
  always_comb begin
    hit = 1'b0;
    capture = 1'b0;
    clear = 1'b0;
    incr = 1'b0;
    fpPhase_next = fpPhase_reg;
    if (cfg.enable) begin
      case (cfg.opMode)
        cpot_pkg::MODE_PERIODIC: begin
          if (tick && count_reg == snap_reg) begin
            hit = 1'b1;
            clear = 1'b1;
          end else begin
            incr = tick;
          end
        end
        cpot_pkg::MODE_TIMEOUT: begin
          incr = tick;
        end
        cpot_pkg::MODE_CAPTURE: begin
          incr = tick;
          if (actSel) begin
            capture = 1'b1;
            hit = 1'b1;
          end
        end
        cpot_pkg::MODE_FREQ: begin
          incr = tick;
          if (actSel) begin
            capture = 1'b1;
            hit = 1'b1;
            clear = 1'b1;
          end
        end
        cpot_pkg::MODE_PW: begin
          incr = tick;
          if (actRise) begin
            clear = 1'b1;
          end else if (actFall) begin
            capture = 1'b1;
            hit = 1'b1;
          end
        end
        cpot_pkg::MODE_FREQ_PW: begin
          case (fpPhase_reg)
            2'h0: begin
              if (actRise) begin
                clear = 1'b1;
                fpPhase_next = 2'h1;
              end
            end
            2'h1: begin
              incr = tick;
              if (actFall) begin
                capture = 1'b1;
                fpPhase_next = 2'h2;
              end
            end
            2'h2: begin
              if (actRise) begin
                hit = 1'b1;
                fpPhase_next = 2'h3;
              end else begin
                incr = tick;
              end
            end
            default: begin
              if (!flag_reg) begin
                fpPhase_next = 2'h0;
              end
            end
          endcase
        end
        cpot_pkg::MODE_SINGLE: begin
          clear = (ss_reg == cpot_pkg::SS_ARM);
          if (ss_reg == cpot_pkg::SS_RUN && tick) begin
            if (count_reg == snap_reg) begin
              hit = 1'b1;
            end else begin
              incr = 1'b1;
            end
          end
        end
        cpot_pkg::MODE_PWM8: begin
          if (tick) begin
            if (count_reg[7:0] >= snap_reg[7:0]) begin
              clear = 1'b1;
            end else begin
              incr = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // counter and snapshot
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_reg <= cpot_pkg::RST_WORD;
    end else if (clkEn) begin
      if (wrStrobe && idx == cpot_pkg::IDX_COUNT_HI) begin
        count_reg <= {wb_dat_i[7:0], temp_reg};
      end else if (cfg.enable && cfg.restartFollow && partnerRestart) begin
        count_reg <= cpot_pkg::RST_WORD;
      end else if (clear) begin
        count_reg <= cpot_pkg::RST_WORD;
      end else if (incr) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      snap_reg <= cpot_pkg::RST_WORD;
    end else if (clkEn) begin
      if (wrStrobe && idx == cpot_pkg::IDX_SNAP_HI) begin
        snap_reg <= {wb_dat_i[7:0], temp_reg};
      end else if (capture) begin
        snap_reg <= count_reg;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fpPhase_reg <= 2'h0;
    end else if (clkEn) begin
      fpPhase_reg <= (cfg.opMode == cpot_pkg::MODE_FREQ_PW) ? fpPhase_next : 2'h0;
    end
  end

  // snapshot flag: a new hit wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flag_reg <= 1'b0;
    end else if (clkEn) begin
      if (hit) begin
        flag_reg <= 1'b1;
      end else if (snapLoRead) begin
        flag_reg <= 1'b0;
      end else if (wrStrobe && idx == cpot_pkg::IDX_IRQ_FLAG
          && wb_dat_i[cpot_pkg::BIT_FLAG]) begin
        flag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      evOut_reg <= 1'b0;
    end else if (clkEn) begin
      evOut_reg <= hit;
    end
  end

  assign eventOut = evOut_reg;

  // single-shot sequencing
  always_comb begin
    ss_next = ss_reg;
    case (ss_reg)
      cpot_pkg::SS_IDLE: begin
        if (cfg.enable && !enPrev_reg && count_reg != cpot_pkg::COUNT_TOP) begin
          ss_next = cpot_pkg::SS_RUN;
        end else if (cfg.enable && ssTrig) begin
          ss_next = cpot_pkg::SS_ARM;
        end
      end
      cpot_pkg::SS_ARM: ss_next = cpot_pkg::SS_RUN;
      cpot_pkg::SS_RUN: begin
        if (hit) begin
          ss_next = cpot_pkg::SS_HOLD;
        end
      end
      cpot_pkg::SS_HOLD: begin
        if (tick) begin
          ss_next = cpot_pkg::SS_IDLE;
        end
      end
      default: ss_next = cpot_pkg::SS_IDLE;
    endcase
    if (!cfg.enable || cfg.opMode != cpot_pkg::MODE_SINGLE) begin
      ss_next = cpot_pkg::SS_IDLE;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ss_reg <= cpot_pkg::SS_IDLE;
    end else if (clkEn) begin
      ss_reg <= ss_next;
    end
  end

  assign running = cfg.enable
      && (cfg.opMode != cpot_pkg::MODE_SINGLE || ss_reg == cpot_pkg::SS_RUN);
  assign pwmLvl = count_reg[7:0] < snap_reg[15:8];

  // waveform pin; output enable is active low
  always_comb begin
    waveOeN = ~cfg.waveOn;
    waveOut = 1'b0;
    if (cfg.waveOn) begin
      case (cfg.opMode)
        cpot_pkg::MODE_SINGLE: begin
          waveOut = (ss_reg == cpot_pkg::SS_RUN)
              || (cfg.asyncOut && ss_reg == cpot_pkg::SS_ARM)
              || (cfg.asyncOut && cfg.enable && ss_reg == cpot_pkg::SS_IDLE && ssTrig);
        end
        cpot_pkg::MODE_PWM8: waveOut = pwmLvl;
        default: waveOut = cfg.waveInit;
      endcase
    end
  end

endmodule : cpot_timer

// ### verification/cpot_partner.sv
`timescale 1ns/100ps
module cpot_partner #(
  parameter int TICK_DIV = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // bench request
  input wire logic evReq,
  // timer side
  output logic eventIn,
  output logic partnerTick,
  output logic partnerRestart
);
  logic [7:0] divReg;
  logic [3:0] wrapReg;
  // event level changes only after an edge and holds whole cycles
  always_ff @(posedge mclk) eventIn <= !sys_rst && evReq;
  always_ff @(posedge mclk) begin
    divReg <= (sys_rst || partnerTick) ? 8'h00 : divReg + 8'h01;
    wrapReg <= sys_rst ? 4'h0 : wrapReg + 4'(partnerTick);
  end
  assign partnerTick = divReg == 8'(TICK_DIV - 1);
  // companion count restarts when its tick count wraps
  assign partnerRestart = partnerTick && wrapReg == 4'hf;
endmodule : cpot_partner

// ### verification/cpot_timer_sva.sv
`timescale 1ns/100ps
module cpot_timer_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // bus
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // event and pin
  input wire logic eventOut,
  input wire logic waveOut,
  input wire logic waveOeN
);
  default clocking cb @(posedge mclk);
  endclocking
  property p_ack_one;
    disable iff (sys_rst) wb_ack_o && clkEn |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack wider than one cycle");
  property p_ack_take;
    disable iff (sys_rst) wb_cyc_i && wb_stb_i && !wb_ack_o && clkEn |=> wb_ack_o;
  endproperty
  a_ack_take: assert property (p_ack_take) else $error("request not acked");
  property p_ack_cause;
    disable iff (sys_rst) wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_zero;
    disable iff (sys_rst) wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_dat_zero: assert property (p_dat_zero) else $error("upper read bits set");
  property p_evt_one;
    disable iff (sys_rst) eventOut && clkEn |=> !eventOut;
  endproperty
  a_evt_one: assert property (p_evt_one) else $error("event pulse too long");
  property p_rst_quiet;
    sys_rst && clkEn |=> !wb_ack_o && !eventOut;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("activity in reset");
  property p_rst_pin;
    sys_rst && clkEn |=> waveOeN && !waveOut;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("pin driven in reset");
  property p_oe_cause;
    disable iff (sys_rst) $changed(waveOeN) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("enable moved without write");
  c_evt: cover property ($rose(eventOut));
  c_wave: cover property ($rose(waveOut));
  c_wr: cover property (wb_ack_o && wb_we_i);
endmodule : cpot_timer_sva
bind cpot_timer cpot_timer_sva u_sva (.mclk, .sys_rst, .clkEn, .wb_we_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .eventOut, .waveOut, .waveOeN);

// ### verification/cpot_timer_tb.sv
`timescale 1ns/100ps
module cpot_timer_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic evReq = 1'b0;
  logic evPrev = 1'b0;
  logic wPrev = 1'b0;
  logic [31:0] rdat;
  logic ack, eventIn, eventOut, pTick, pRst, waveOut, waveOeN;
  logic [15:0] lf = 16'h0009;
  logic [15:0] s1, s2;
  int failures, checks, now, evCnt, evT, riseT, hiCnt, hiLen, perLen, t1, p, q, c;
  int rstT, evR;
  always #2.5 mclk = ~mclk;
  cpot_timer uut (.mclk, .sys_rst, .clkEn(1'b1), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .eventIn, .eventOut, .partnerTick(pTick), .partnerRestart(pRst),
    .waveOut, .waveOeN);
  cpot_partner peer (.mclk, .sys_rst, .evReq, .eventIn, .partnerTick(pTick),
    .partnerRestart(pRst));
  // edge times, pulse widths and event count seen at the pins
  always @(posedge mclk) begin
    now++;
    if (eventOut === 1'b1) evCnt++;
    if (eventIn === 1'b1 && !evPrev) evR = rstT;
    if (eventIn === 1'b1 && !evPrev) evT = now;
    if (waveOut === 1'b1) begin
      hiCnt = wPrev ? hiCnt + 1 : 1;
      if (!wPrev) perLen = now - riseT;
      if (!wPrev) riseT = now;
    end else if (wPrev) hiLen = hiCnt;
    evPrev = eventIn === 1'b1;
    wPrev = waveOut === 1'b1;
    if (pRst === 1'b1) rstT = now;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  // count reached g clocks after a restart
  function automatic logic [15:0] gapCnt(input int g);
    return 16'(g - 1);
  endfunction : gapCnt
  task automatic print_verdict();
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wbx(input logic [5:0] i, input logic w, input logic [7:0] d,
    output logic [7:0] r);
    int n;
    @(posedge mclk);
    adr <= {i, 2'b00};
    we <= w;
    wdat <= {24'h000000, d};
    cyc <= 1'b1;
    stb <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      $display("[ERR] %0t bus timeout", $time);
      print_verdict();
    end
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wbx
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] r;
    wbx(i, 1'b1, d, r);
  endtask : wr
  task automatic rchk(input logic [5:0] i, input logic [7:0] e);
    logic [7:0] d;
    wbx(i, 1'b0, 8'h00, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rchk
  task automatic rd16(input logic [5:0] i, output logic [15:0] v);
    wbx(i, 1'b0, 8'h00, v[7:0]);
    wbx(i + 6'h01, 1'b0, 8'h00, v[15:8]);
  endtask : rd16
  task automatic ev(input logic v, input int n);
    evReq <= v;
    repeat (n) @(posedge mclk);
  endtask : ev
  // stop, set up, preset the count, clear stale flags, then start
  task automatic cfg(input logic [7:0] wave, input logic [7:0] evc, input logic [7:0] cnt);
    wr(cpot_pkg::IDX_CTRL_MAIN, 8'h00);
    wr(cpot_pkg::IDX_CTRL_WAVE, wave);
    wr(cpot_pkg::IDX_EVT_CTRL, evc);
    wr(cpot_pkg::IDX_COUNT_LO, cnt);
    wr(cpot_pkg::IDX_COUNT_HI, cnt);
    wr(cpot_pkg::IDX_IRQ_FLAG, 8'h01);
    wr(cpot_pkg::IDX_CTRL_MAIN, 8'h01);
  endtask : cfg
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int m = 0; m < 8; m++) begin
      wr(cpot_pkg::IDX_CTRL_WAVE, 8'(m));
      rchk(cpot_pkg::IDX_CTRL_WAVE, 8'(m));
    end
    for (int k = 0; k < 3; k++) begin
      wr(cpot_pkg::IDX_CTRL_MAIN, 8'(k << 1));
      rchk(cpot_pkg::IDX_CTRL_MAIN, 8'(k << 1));
    end
    rchk(6'h3f, 8'h00);
    cfg(8'h32, 8'h01, 8'h00);
    chk({14'h0, waveOeN, waveOut}, 16'h0001);
    lf = nxt(lf);
    p = 20 + lf[3:0];
    q = 10 + lf[7:4];
    ev(1'b1, p);
    t1 = evT;
    rd16(cpot_pkg::IDX_SNAP_LO, s1);
    ev(1'b0, 4);
    ev(1'b1, 4);
    rchk(cpot_pkg::IDX_IRQ_FLAG, 8'h01);
    rd16(cpot_pkg::IDX_SNAP_LO, s2);
    chk(s2 - s1, 16'(evT - t1));
    rchk(cpot_pkg::IDX_IRQ_FLAG, 8'h00);
    chk(16'(evCnt), 16'h0002);
    ev(1'b0, 4);
    cfg(8'h02, 8'h11, 8'h00);
    ev(1'b1, 4);
    rchk(cpot_pkg::IDX_IRQ_FLAG, 8'h00);
    ev(1'b0, 4);
    rchk(cpot_pkg::IDX_IRQ_FLAG, 8'h01);
    cfg(8'h03, 8'h01, 8'h00);
    ev(1'b1, 3);
    ev(1'b0, q);
    ev(1'b1, 3);
    rd16(cpot_pkg::IDX_SNAP_LO, s1);
    chk(s1, gapCnt(q + 3));
    ev(1'b0, 3);
    cfg(8'h04, 8'h01, 8'h00);
    ev(1'b1, q);
    ev(1'b0, 3);
    rd16(cpot_pkg::IDX_SNAP_LO, s1);
    chk(s1, gapCnt(q));
    cfg(8'h05, 8'h01, 8'h00);
    ev(1'b1, q);
    ev(1'b0, p);
    ev(1'b1, 3);
    rd16(cpot_pkg::IDX_COUNT_LO, s1);
    chk(s1, gapCnt(q + p));
    rd16(cpot_pkg::IDX_SNAP_LO, s1);
    chk(s1, gapCnt(q));
    ev(1'b0, 3);
    cfg(8'h02, 8'h41, 8'h00);
    chk({15'h0, waveOeN}, 16'h0001);
    ev(1'b1, 2);
    ev(1'b0, 8);
    rchk(cpot_pkg::IDX_IRQ_FLAG, 8'h00);
    ev(1'b1, 8);
    rchk(cpot_pkg::IDX_IRQ_FLAG, 8'h01);
    ev(1'b0, 8);
    // companion tick every four clocks, count follows companion restarts
    cfg(8'h02, 8'h01, 8'h00);
    wr(cpot_pkg::IDX_CTRL_MAIN, 8'h15);
    ev(1'b0, 70);
    ev(1'b1, 8);
    rd16(cpot_pkg::IDX_SNAP_LO, s1);
    chk(s1, 16'((evT - evR - 1) / 4));
    ev(1'b0, 4);
    for (int a = 0; a < 2; a++) begin
      lf = nxt(lf);
      c = 4 + lf[3:0];
      wr(cpot_pkg::IDX_SNAP_LO, 8'(c));
      wr(cpot_pkg::IDX_SNAP_HI, 8'h00);
      cfg({1'b0, 1'(a), 6'h16}, {3'h0, 1'(a), 4'h1}, 8'hff);
      rchk(cpot_pkg::IDX_STATUS, 8'h00);
      ev(1'b1, c + 10);
      chk(16'(riseT - evT), a ? 16'h0000 : 16'h0002);
      chk(16'(hiLen), 16'(c + 1 + 2 * a));
      ev(1'b0, 4);
      chk({15'h0, waveOut}, 16'(a));
      ev(1'b0, c + 6);
    end
    wr(cpot_pkg::IDX_SNAP_LO, 8'(p));
    wr(cpot_pkg::IDX_SNAP_HI, 8'(q - 8));
    cfg(8'h17, 8'h00, 8'h00);
    repeat (3 * (p + 1)) @(posedge mclk);
    chk(16'(hiLen), 16'(q - 8));
    chk(16'(perLen), 16'(p + 1));
    print_verdict();
  end
endmodule : cpot_timer_tb
